// ### hw/swid_link.sv
// slave-side link of a single-wire identification device
// assumes i_line is the wire level synchronous to i_clock; pin is open drain
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - we only pull the wire low through an open-drain enable, never drive high
// RULE2 - holds a 64-bit number: family code, 48-bit serial, crc
// RULE3 - bits go both ways least significant first
// RULE4 - every slot starts at the master's falling edge; only presence is ours
// RULE5 - master waits 1200 us after power-up and tolerates stray presence
// RULE6 - the wire idles high; a paused master keeps it high
// RULE7 - a low period is a slot when short, a reset when long
// RULE8 - master reset low is 480..640 us standard, 60..80 us overdrive
// RULE9 - standard: wait 15..60 us after reset, then presence low 60..240 us
// RULE10 - overdrive: wait 2..6 us, then presence low 8..24 us
// RULE11 - master samples presence 60..75 us standard, by 10 us overdrive
// RULE12 - standard zero write holds low 60..120 us
// RULE13 - overdrive zero write holds low 6..16 us
// RULE14 - one write low 5 to under 15 us, overdrive 1 to under 2 us
// RULE15 - read slot starts with the same short low as a one write
// RULE16 - master samples read data by 15 us, overdrive 2 us
// RULE17 - low time counts from the falling to the rising crossing
// RULE18 - master order: initialise, rom command, read data
// RULE19 - every transaction opens with reset and presence
// RULE20 - bit rate stays under 15.4 kbps standard, 125 kbps overdrive
// RULE21 - the overdrive skip command byte switches to overdrive timing
// RULE22 - reset of 480 us or more leaves overdrive; short resets keep it
// RULE23 - read slot: pull low for a zero bit, stay released for a one
// RULE24 - written bit sampled after longest one low, before shortest zero low
// RULE25 - falls are ignored until our own drive ends and the wire is high
module swid_link
   import swid_pkg::*;
#(
   parameter logic [7:0]       P_FAMILY      = FAMILY_DEFAULT,
   parameter logic [47:0]      P_SERIAL      = SERIAL_DEFAULT,
   parameter logic [CNT_W-1:0] P_STD_RST_CNT = STD_RST_DET_CNT,
   parameter logic [CNT_W-1:0] P_OD_RST_CNT  = OD_RST_DET_CNT,
   parameter logic [CNT_W-1:0] P_EXIT_CNT    = STD_EXIT_CNT,
   parameter logic [CNT_W-1:0] P_STD_PRES    = STD_PRES_CNT
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic        i_clk_en,
   // wire pin
   input  wire logic        i_line,
   output logic             o_line_out,
   output logic             o_line_oe_n,
   // received bytes
   output logic             o_rx_valid,
   output logic [FIFO_W-1:0] o_rx_data,
   input  wire logic        i_rx_ready,
   // status
   output logic             o_fast_speed_flag,
   output logic             o_reset_seen,
   output logic             o_overrun
);

   // ******************************************************
   // identity number
   // ******************************************************
   localparam logic [ROM_BITS-1:0] ROM_VALUE =
      {crc8({P_SERIAL, P_FAMILY}), P_SERIAL, P_FAMILY}; // RULE2

   // ******************************************************
   // state
   // ******************************************************
   swid_state_t      state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             line_prev_r;
   logic             fast_r;
   logic             oe_n_r;
   logic             low_at_samp_r;
   logic             tx_mode_r;
   logic             cmd_phase_r;
   logic [5:0]       rom_idx_r;
   logic [7:0]       shift_r;
   logic [2:0]       bitcnt_r;
   logic             pend_r;
   logic [7:0]       pend_byte_r;
   logic             rst_seen_r;
   logic             overrun_r;

   // ******************************************************
   // decode
   // ******************************************************
   logic             fall;
   logic [CNT_W-1:0] samp_cnt, rst_cnt, pwait_cnt, pres_cnt;
   logic             at_samp, slot_end, is_reset, bit_commit, rx_bit;
   logic             tx_zero, byte_done, fifo_ready, drive_nxt;
   logic [7:0]       rx_byte;

   assign fall       = line_prev_r & ~i_line;                        // RULE4
   assign samp_cnt   = fast_r ? OD_SAMPLE_CNT : STD_SAMPLE_CNT;      // RULE24 RULE20
   assign rst_cnt    = fast_r ? P_OD_RST_CNT  : P_STD_RST_CNT;
   assign pwait_cnt  = fast_r ? OD_PWAIT_CNT  : STD_PWAIT_CNT;       // RULE9 RULE10
   assign pres_cnt   = fast_r ? OD_PRES_CNT   : P_STD_PRES;          // RULE9 RULE10
   assign at_samp    = (state_r == S_LOW) && (cnt_r == samp_cnt);
   // low time ends only when the wire is back high and we are not holding it
   assign slot_end   = (state_r == S_LOW) && i_line && oe_n_r;       // RULE17 RULE25
   assign is_reset   = slot_end && (cnt_r >= rst_cnt);               // RULE7
   assign bit_commit = slot_end && !is_reset;                        // RULE7
   assign rx_bit     = ~low_at_samp_r;                               // RULE24
   assign rx_byte    = {rx_bit, shift_r[7:1]};                       // RULE3
   assign byte_done  = bit_commit && !tx_mode_r && (bitcnt_r == 3'h7);
   assign tx_zero    = tx_mode_r && !ROM_VALUE[rom_idx_r];           // RULE3 RULE23

   // drive is a registered enable only; data pin is a constant low
   assign drive_nxt  = (state_nxt == S_PRES) ||
                       ((state_nxt == S_LOW) && tx_zero && (cnt_nxt < samp_cnt)); // RULE23

   // ******************************************************
   // sequencing
   // ******************************************************
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
      case (state_r)
         S_IDLE: begin
            cnt_nxt = '0;
            if (fall)                                                // RULE6
               state_nxt = S_LOW;
         end
         S_LOW: begin
            if (is_reset) begin
               state_nxt = S_PWAIT;
               cnt_nxt   = '0;
            end else if (slot_end) begin
               state_nxt = S_IDLE;
               cnt_nxt   = '0;
            end
         end
         S_PWAIT: begin
            if (fall) begin
               state_nxt = S_LOW;
               cnt_nxt   = '0;
            end else if (cnt_r >= pwait_cnt - 1'b1) begin
               state_nxt = S_PRES;
               cnt_nxt   = '0;
            end
         end
         S_PRES: begin
            if (cnt_r >= pres_cnt - 1'b1)
               state_nxt = S_REL;
         end
         S_REL: begin
            cnt_nxt = '0;
            if (i_line)                                              // RULE25
               state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
            cnt_nxt   = '0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r     <= S_IDLE;
         cnt_r       <= '0;
         line_prev_r <= 1'b1;
         oe_n_r      <= 1'b1;
      end else if (i_clk_en) begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         line_prev_r <= i_line;
         oe_n_r      <= ~drive_nxt;                                  // RULE1
      end
   end

   // ******************************************************
   // bit capture and rom shifting
   // ******************************************************
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         low_at_samp_r <= 1'b0;
         shift_r       <= 8'h00;
         bitcnt_r      <= 3'h0;
         rom_idx_r     <= 6'h00;
         tx_mode_r     <= 1'b0;
      end else if (i_clk_en) begin
         // a fall during presence wait also opens a fresh low
         if ((state_r == S_IDLE || state_r == S_PWAIT) && fall)
            low_at_samp_r <= 1'b0;
         else if (at_samp && !i_line)
            low_at_samp_r <= 1'b1;                                   // RULE24
         if (is_reset) begin
            bitcnt_r  <= 3'h0;
            tx_mode_r <= 1'b0;
         end else if (bit_commit && tx_mode_r) begin
            rom_idx_r <= rom_idx_r + 6'h01;
            if (rom_idx_r == 6'h3F)
               tx_mode_r <= 1'b0;
         end else if (bit_commit) begin
            shift_r  <= rx_byte;
            bitcnt_r <= bitcnt_r + 3'h1;
         end
         if (byte_done && cmd_phase_r && rx_byte == CMD_READ_ROM) begin
            tx_mode_r <= 1'b1;
            rom_idx_r <= 6'h00;
         end
      end
   end

   // ******************************************************
   // command byte, speed flag, status
   // ******************************************************
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_phase_r <= 1'b1;
         fast_r      <= 1'b0;
         rst_seen_r  <= 1'b0;
      end else if (i_clk_en) begin
         rst_seen_r <= is_reset;
         if (is_reset) begin
            cmd_phase_r <= 1'b1;
            if (cnt_r >= P_EXIT_CNT)
               fast_r <= 1'b0;                                       // RULE22
         end else if (byte_done && cmd_phase_r) begin
            cmd_phase_r <= 1'b0;
            if (rx_byte == CMD_FAST_SKIP)
               fast_r <= 1'b1;                                       // RULE21
         end
      end
   end

   // ******************************************************
   // hand-off to the fifo
   // ******************************************************
   // one byte waits here while the fifo is full; a second one is dropped
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         pend_r      <= 1'b0;
         pend_byte_r <= 8'h00;
         overrun_r   <= 1'b0;
      end else if (i_clk_en) begin
         overrun_r <= byte_done && pend_r && !fifo_ready;
         if (byte_done && (!pend_r || fifo_ready)) begin
            pend_r      <= 1'b1;
            pend_byte_r <= rx_byte;
         end else if (fifo_ready) begin
            pend_r <= 1'b0;
         end
      end
   end

   swid_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_nrst      (i_nrst),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (pend_r),
      .i_in_data   (pend_byte_r),
      .o_in_ready  (fifo_ready),
      .o_out_valid (o_rx_valid),
      .o_out_data  (o_rx_data),
      .i_out_ready (i_rx_ready)
   );

   assign o_line_out        = 1'b0;                                  // RULE1
   assign o_line_oe_n       = oe_n_r;
   assign o_fast_speed_flag = fast_r;
   assign o_reset_seen      = rst_seen_r;
   assign o_overrun         = overrun_r;

endmodule : swid_link
`default_nettype wire

// ### hw/swid_pkg.sv
// constants, states and helpers for the single-wire identification slave link
// assumes a 125 MHz system clock; all counts derive from the period below
package swid_pkg;

   // ******************************************************
   // clock and widths
   // ******************************************************
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          CNT_W         = 16;
   localparam int          ROM_BITS      = 64;
   localparam int          FIFO_W        = 8;
   localparam int          FIFO_DEPTH    = 8;

   // ******************************************************
   // times in ns
   // ******************************************************
   localparam int          STD_RST_DET_NS  = 240000;  // above longest zero write low
   localparam int          OD_RST_DET_NS   = 40000;   // above overdrive zero write low
   localparam int          STD_EXIT_NS     = 480000;  // reset this long leaves overdrive
   localparam int          STD_SAMPLE_NS   = 30000;   // between 15 and 60 us
   localparam int          OD_SAMPLE_NS    = 3000;    // between 2 and 6 us
   localparam int          STD_PWAIT_NS    = 30000;   // within 15..60 us
   localparam int          OD_PWAIT_NS     = 3000;    // within 2..6 us
   localparam int          STD_PRES_NS     = 120000;  // within 60..240 us
   localparam int          OD_PRES_NS      = 16000;   // within 8..24 us

   function automatic int cyc_ceil(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : cyc_ceil

   // ******************************************************
   // cycle counts
   // ******************************************************
   localparam logic [CNT_W-1:0] STD_RST_DET_CNT = CNT_W'(cyc_ceil(STD_RST_DET_NS));
   localparam logic [CNT_W-1:0] OD_RST_DET_CNT  = CNT_W'(cyc_ceil(OD_RST_DET_NS));
   localparam logic [CNT_W-1:0] STD_EXIT_CNT    = CNT_W'(cyc_ceil(STD_EXIT_NS));
   localparam logic [CNT_W-1:0] STD_PRES_CNT    = CNT_W'(cyc_ceil(STD_PRES_NS));
   localparam logic [CNT_W-1:0] STD_SAMPLE_CNT  = CNT_W'(cyc_ceil(STD_SAMPLE_NS));
   localparam logic [CNT_W-1:0] OD_SAMPLE_CNT   = CNT_W'(cyc_ceil(OD_SAMPLE_NS));
   localparam logic [CNT_W-1:0] STD_PWAIT_CNT   = CNT_W'(cyc_ceil(STD_PWAIT_NS));
   localparam logic [CNT_W-1:0] OD_PWAIT_CNT    = CNT_W'(cyc_ceil(OD_PWAIT_NS));
   localparam logic [CNT_W-1:0] OD_PRES_CNT     = CNT_W'(cyc_ceil(OD_PRES_NS));

   // ******************************************************
   // commands, identity, reset values
   // ******************************************************
   localparam logic [7:0]  CMD_READ_ROM   = 8'h33;
   localparam logic [7:0]  CMD_FAST_SKIP  = 8'h3C;
   localparam logic [7:0]  FAMILY_DEFAULT = 8'hA5;           // arbitrary value
   localparam logic [47:0] SERIAL_DEFAULT = 48'h0123456789AB; // arbitrary value

   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_LOW   = 5'h02,
      S_PWAIT = 5'h04,
      S_PRES  = 5'h08,
      S_REL   = 5'h10
   } swid_state_t;

   // crc-8, polynomial x^8+x^5+x^4+1, fed lsb first
   function automatic logic [7:0] crc8(input logic [55:0] data);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         fb = c[0] ^ data[i];
         c  = {1'b0, c[7:1]} ^ (fb ? 8'h8C : 8'h00);
      end
      return c;
   endfunction : crc8

endpackage : swid_pkg

// ### hw/swid_fifo.sv
// shift-register fifo with registered head and valid
// assumes one clock; push and pop may happen in the same cycle
`timescale 1ns/1ps
`default_nettype none
module swid_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_nrst,
   input  wire logic         i_clk_en,
   // fill side
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   // drain side
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_r [DEPTH];
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic [CW-1:0] wr_idx;
   logic          valid_r;
   logic          push;
   logic          pop;

   assign o_in_ready  = (count_r != CW'(DEPTH));
   assign push        = i_in_valid & o_in_ready;
   assign pop         = valid_r & i_out_ready;
   assign wr_idx      = count_r - CW'(pop);
   assign count_nxt   = count_r + CW'(push) - CW'(pop);
   assign o_out_valid = valid_r;
   assign o_out_data  = mem_r[0];

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         count_r <= '0;
         valid_r <= 1'b0;
      end else if (i_clk_en) begin
         count_r <= count_nxt;
         valid_r <= (count_nxt != '0);
      end
   end

   // storage has no reset; valid guards the head
   always_ff @(posedge i_clock) begin
      if (i_clk_en) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (push && (wr_idx == CW'(i)))
               mem_r[i] <= i_in_data;
            else if (pop && (i < DEPTH - 1))
               mem_r[i] <= mem_r[(i + 1) % DEPTH];
         end
      end
   end
endmodule : swid_fifo
`default_nettype wire

// ### verification/swid_master_model.sv
// bus master model for the single-wire slave link
// assumes o_line feeds the slave's line input; slots packed to keep runs short
`timescale 1ns/1ps
`default_nettype none
module swid_master_model (
   // clock
   input  wire logic i_clock,
   // wire
   input  wire logic i_oe_n,
   output logic      o_line
);
   logic pull_r = 1'b0;
   // ****
   // wire and slots
   // ****
   // pull-up wins only when nobody pulls low
   assign o_line = ~pull_r & i_oe_n;
   task automatic hold_low(input int n);
      @(posedge i_clock) pull_r <= 1'b1;
      repeat (n) @(posedge i_clock);
      pull_r <= 1'b0;
   endtask : hold_low
   // short recovery: data rate limit traded for run time
   task automatic recover();
      int k;
      k = 0;
      @(posedge i_clock);
      while (o_line !== 1'b1 && k < 20000) begin
         @(posedge i_clock);
         k++;
      end
      repeat (2) @(posedge i_clock);
   endtask : recover
   task automatic reset_pulse(input int n, input int smp, output logic pres);
      hold_low(n);
      repeat (smp) @(posedge i_clock);
      pres = ~o_line;
      recover();
   endtask : reset_pulse
   task automatic write_byte(input logic [7:0] b, input int z, input int o);
      for (int i = 0; i < 8; i++) begin
         hold_low(b[i] ? o : z);
         recover();
      end
   endtask : write_byte
   task automatic read_bits(input int l, input int smp, output logic [63:0] v);
      for (int i = 0; i < 64; i++) begin
         hold_low(l);
         repeat (smp - l) @(posedge i_clock);
         v[i] = o_line;
         recover();
      end
   endtask : read_bits
endmodule : swid_master_model
`default_nettype wire

// ### verification/swid_link_assertions.sv
// assertions on the pins of the single-wire slave link
// assumes bind to swid_link; i_line is the resolved wire level
`timescale 1ns/1ps
`default_nettype none
module swid_link_assertions
   import swid_pkg::*;
#(
   parameter logic [CNT_W-1:0] P_STD_RST_CNT = STD_RST_DET_CNT,
   parameter logic [CNT_W-1:0] P_OD_RST_CNT  = OD_RST_DET_CNT,
   parameter logic [CNT_W-1:0] P_EXIT_CNT    = STD_EXIT_CNT,
   parameter logic [CNT_W-1:0] P_STD_PRES    = STD_PRES_CNT
) (
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_nrst,
   input  wire logic              i_clk_en,
   // wire pin
   input  wire logic              i_line,
   input  wire logic              o_line_out,
   input  wire logic              o_line_oe_n,
   // received bytes
   input  wire logic              o_rx_valid,
   input  wire logic [FIFO_W-1:0] o_rx_data,
   input  wire logic              i_rx_ready,
   // status
   input  wire logic              o_fast_speed_flag,
   input  wire logic              o_reset_seen,
   input  wire logic              o_overrun
);
   logic [CNT_W-1:0] rs_cnt_r, ll_cnt_r, last_low_r, oel_cnt_r;
   logic             line_prev_r, pres_r;
   wire logic [CNT_W-1:0] pwait_w, thr_w, pres_w, smp_w;
   assign pwait_w = o_fast_speed_flag ? OD_PWAIT_CNT : STD_PWAIT_CNT;
   assign thr_w   = o_fast_speed_flag ? P_OD_RST_CNT : P_STD_RST_CNT;
   assign pres_w  = o_fast_speed_flag ? OD_PRES_CNT : P_STD_PRES;
   assign smp_w   = o_fast_speed_flag ? OD_SAMPLE_CNT : STD_SAMPLE_CNT;
   function automatic logic [CNT_W-1:0] sat(input logic [CNT_W-1:0] x);
      return (&x) ? x : x + 16'h0001;
   endfunction : sat
   // the reset count starts saturated so a presence without a reset fails
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rs_cnt_r    <= '1;
         ll_cnt_r    <= '0;
         last_low_r  <= '0;
         oel_cnt_r   <= '0;
         line_prev_r <= 1'b1;
         pres_r      <= 1'b0;
      end else begin
         rs_cnt_r    <= o_reset_seen ? '0 : sat(rs_cnt_r);
         ll_cnt_r    <= i_line ? '0 : sat(ll_cnt_r);
         last_low_r  <= (i_line && !line_prev_r) ? ll_cnt_r : last_low_r;
         oel_cnt_r   <= o_line_oe_n ? '0 : sat(oel_cnt_r);
         pres_r      <= o_line_oe_n ? 1'b0 : (oel_cnt_r == '0) ? line_prev_r : pres_r;
         line_prev_r <= i_line;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   sequence s_pres_start;
      $fell(o_line_oe_n) && $past(i_line);
   endsequence
   sequence s_drive_end;
      $rose(o_line_oe_n);
   endsequence
   a_drain_only: assert property (o_line_out == 1'b0)
      else $error("line output not zero");
   a_pres_wait: assert property (s_pres_start |-> rs_cnt_r inside {[pwait_w - 16'h0006 : pwait_w + 16'h0003]})
      else $error("presence wait wrong");
   a_pres_len: assert property ((s_drive_end ##0 pres_r) |-> oel_cnt_r inside {[pres_w - 16'h0003 : pres_w + 16'h0003]})
      else $error("presence length wrong");
   a_read_zero: assert property ((s_drive_end ##0 !pres_r) |-> oel_cnt_r inside {[smp_w - 16'h0008 : smp_w]})
      else $error("read zero length wrong");
   a_read_cause: assert property ($fell(o_line_oe_n) && !$past(i_line) |-> ll_cnt_r inside {[1:5]})
      else $error("drive without master fall");
   a_reset_class: assert property (o_reset_seen |-> last_low_r >= thr_w - 16'h0004)
      else $error("short low taken as reset");
   a_long_low: assert property ($rose(i_line) && $past(o_line_oe_n) && ll_cnt_r >= thr_w + 16'h0004 |-> ##[0:3] o_reset_seen)
      else $error("long low not taken as reset");
   a_fast_exit: assert property ($fell(o_fast_speed_flag) |-> ll_cnt_r >= P_EXIT_CNT - 16'h0002 || last_low_r >= P_EXIT_CNT - 16'h0002)
      else $error("fast flag cleared by short low");
   a_fast_keep: assert property (o_reset_seen && last_low_r < P_EXIT_CNT - 16'h0008 && $past(o_fast_speed_flag) |-> o_fast_speed_flag)
      else $error("fast flag lost on short reset");
   a_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
      else $error("rx head changed while stalled");
endmodule : swid_link_assertions
bind swid_link swid_link_assertions #(
   .P_STD_RST_CNT(P_STD_RST_CNT),
   .P_OD_RST_CNT (P_OD_RST_CNT),
   .P_EXIT_CNT   (P_EXIT_CNT),
   .P_STD_PRES   (P_STD_PRES)
) i_swid_link_assertions (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
   .i_line(i_line), .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n),
   .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready),
   .o_fast_speed_flag(o_fast_speed_flag), .o_reset_seen(o_reset_seen),
   .o_overrun(o_overrun));
`default_nettype wire

// ### verification/swid_link_bench.sv
// self-checking bench for the single-wire slave link
// assumes the master model resolves the wire; long counts shortened
`timescale 1ns/1ps
`default_nettype none
module swid_link_bench;
   import swid_pkg::*;
   logic                   clock    = 1'b0;
   logic                   nrst     = 1'b0;
   logic                   rx_ready = 1'b0;
   logic                   clk_en   = 1'b1;
   wire logic              line, oe_n, line_out, rx_valid, fast, rs_seen, overrun;
   wire logic [FIFO_W-1:0] rx_data;
   int                     n_fail = 0;
   int                     comparisons = 0;
   int                     n_rs = 0;
   int                     n_ovr = 0;
   initial begin
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (rs_seen === 1'b1) n_rs++;
      if (overrun === 1'b1) n_ovr++;
   end
   swid_link #(.P_STD_RST_CNT(16'h1F40), .P_OD_RST_CNT(16'h03E8),
      .P_EXIT_CNT(16'h2328), .P_STD_PRES(16'h07D0)) i_swid_link (
      .i_clock(clock), .i_nrst(nrst), .i_clk_en(clk_en), .i_line(line),
      .o_line_out(line_out), .o_line_oe_n(oe_n), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .i_rx_ready(rx_ready), .o_fast_speed_flag(fast),
      .o_reset_seen(rs_seen), .o_overrun(overrun));
   swid_master_model i_swid_master_model (.i_clock(clock), .i_oe_n(oe_n), .o_line(line));
   // ****
   // checking and closing
   // ****
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   function automatic logic [7:0] ref_crc(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
      return c;
   endfunction : ref_crc
   // ****
   // scenarios
   // ****
   task automatic t_std_init();
      logic p;
      i_swid_master_model.reset_pulse(8100, 5000, p);
      check("presence", p, 1'b1);
      check("reset count", n_rs, 1);
      check("fast flag", fast, 1'b0);
      $display("test std_init done");
   endtask : t_std_init
   // zeros at the shortest low, ones just under the longest
   task automatic t_fast_cmd();
      logic p;
      i_swid_master_model.write_byte(CMD_FAST_SKIP, 7500, 1874);
      check("fast set", fast, 1'b1);
      i_swid_master_model.reset_pulse(7500, 1250, p);
      check("fast presence", p, 1'b1);
      check("fast kept", fast, 1'b1);
      $display("test fast_cmd done");
   endtask : t_fast_cmd
   task automatic t_rom_read();
      logic [63:0] v;
      i_swid_master_model.write_byte(CMD_READ_ROM, 750, 249);
      i_swid_master_model.read_bits(125, 200, v);
      check("rom", v, {ref_crc({SERIAL_DEFAULT, FAMILY_DEFAULT}), SERIAL_DEFAULT, FAMILY_DEFAULT});
      $display("test rom_read done");
   endtask : t_rom_read
   // consumer stalls until the tenth byte is dropped
   task automatic t_fifo_fill();
      logic [7:0] e;
      for (int i = 0; i < 8; i++) i_swid_master_model.write_byte(8'hFF ^ (8'h01 << i), 750, 125);
      check("overrun count", n_ovr, 1);
      // clock enable low: a held ready must not pop the head
      clk_en   <= 1'b0;
      rx_ready <= 1'b1;
      repeat (3) @(posedge clock);
      rx_ready <= 1'b0;
      clk_en   <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         e = (i == 0) ? CMD_FAST_SKIP : (i == 1) ? CMD_READ_ROM : 8'hFF ^ (8'h01 << (i - 2));
         repeat (2) @(posedge clock);
         check("rx byte", {rx_valid, rx_data}, {1'b1, e});
         rx_ready <= 1'b1;
         @(posedge clock);
         rx_ready <= 1'b0;
      end
      repeat (2) @(posedge clock);
      check("rx empty", rx_valid, 1'b0);
      $display("test fifo_fill done");
   endtask : t_fifo_fill
   task automatic t_exit();
      logic p;
      i_swid_master_model.reset_pulse(9100, 5000, p);
      check("fast cleared", fast, 1'b0);
      check("std presence", p, 1'b1);
      check("reset total", n_rs, 3);
      $display("test exit done");
   endtask : t_exit
   initial begin
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (100) @(posedge clock);
      t_std_init();
      t_fast_cmd();
      t_rom_read();
      t_fifo_fill();
      t_exit();
      end_of_test();
   end
   initial begin
      repeat (140000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
endmodule : swid_link_bench
`default_nettype wire
